// *** design/fpdc_ctrl.sv ***
`timescale 1ns/10ps
module fpdc_ctrl
    import fpdc_pkg::*;
#(
    parameter int POWERUP_WAIT_CYC = POWERUP_CYC,
    parameter int ROW_MAX_CYC = RAS_MAX_CYC
)
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic wide_mode,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_write,
    input wire logic req_half,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic [LANES-1:0] req_lanes,
    input wire logic [DATA_W-1:0] req_wdata,
    output logic rsp_valid,
    output logic [DATA_W-1:0] rsp_rdata,
    output logic init_done,
    output logic row_strobe_lower_n,
    output logic row_strobe_upper_n,
    output logic [LANES-1:0] lane_column_strobes_n,
    output logic [HALF_W-1:0] mux_address_lines,
    output logic write_n,
    input wire logic [DATA_W-1:0] data_lines_in,
    output logic [DATA_W-1:0] data_lines_out,
    output logic data_lines_oe
);
    fpdc_state_e state_r;
    fpdc_cnt_t row_cnt_r;
    fpdc_cnt_t pwr_cnt_r;
    fpdc_cnt_t ref_cnt_r;
    logic [3:0] wake_cnt_r;
    logic ref_pend_r;
    logic init_r;
    logic [DATA_W-1:0] dq_meta_r;
    logic [DATA_W-1:0] dq_sync_r;
    logic [HALF_W-1:0] cur_row_r;
    logic [HALF_W-1:0] cur_col_r;
    logic [1:0] row_sel_r;
    logic [LANES-1:0] lanes_r;
    logic wr_r;
    logic rsp_valid_r;
    logic [DATA_W-1:0] rsp_rdata_r;
    logic row_lo_n_r;
    logic row_up_n_r;
    logic [LANES-1:0] col_n_r;
    logic [HALF_W-1:0] addr_r;
    logic we_n_r;
    logic [DATA_W-1:0] dout_r;
    logic doe_r;
    logic [1:0] req_sel;
    logic page_hit;
    logic col_end;
    logic ref_tick;

    fpdc_tmr_if tif ();

    fpdc_timer u_timer (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .t(tif)
    );

    // --------------------------------------------------------------------
    // Request decode
    // --------------------------------------------------------------------
    always_comb
    begin
        if (wide_mode)
        begin
            req_sel = 2'h3;
        end
        else
        begin
            req_sel = req_half ? 2'h2 : 2'h1;
        end
    end

    // Read data is only taken once both access paths are satisfied.
    assign col_end = (state_r == S_COL) && tif.done
        && (row_cnt_r >= fpdc_cnt_t'(RAC_CYC + SYNC_STAGES));

    // A page continues only for the same row and well inside the row limit.
    assign page_hit = req_valid && !ref_pend_r && (req_sel == row_sel_r)
        && (req_addr[ADDR_W-1:HALF_W] == cur_row_r)
        && (row_cnt_r < fpdc_cnt_t'(ROW_MAX_CYC - PAGE_MARGIN_CYC));

    assign req_ready = ((state_r == S_IDLE) && init_r && !ref_pend_r)
        || (col_end && page_hit);

    // --------------------------------------------------------------------
    // Data pin synchroniser
    // --------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            dq_meta_r <= '0;
            dq_sync_r <= '0;
        end
        else
        begin
            dq_meta_r <= data_lines_in;
            dq_sync_r <= dq_meta_r;
        end
    end

    // --------------------------------------------------------------------
    // Row activity counter, restarted at every row strobe fall
    // --------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            row_cnt_r <= '0;
        end
        else if (state_r == S_ROWSET || (state_r == S_CBR_SET && tif.done))
        begin
            row_cnt_r <= '0;
        end
        else if (row_cnt_r != '1)
        begin
            row_cnt_r <= row_cnt_r + fpdc_cnt_t'(1);
        end
    end

    // --------------------------------------------------------------------
    // Power-up wait and refresh scheduling
    // --------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pwr_cnt_r <= '0;
        end
        else if (state_r == S_PWR)
        begin
            pwr_cnt_r <= pwr_cnt_r + fpdc_cnt_t'(1);
        end
    end

    assign ref_tick = init_r && (ref_cnt_r == '0);

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ref_cnt_r <= '0;
            ref_pend_r <= 1'b0;
        end
        else
        begin
            if (!init_r || ref_tick)
            begin
                ref_cnt_r <= fpdc_cnt_t'(REF_ROW_CYC - 1);
            end
            else
            begin
                ref_cnt_r <= ref_cnt_r - fpdc_cnt_t'(1);
            end
            // A new tick wins over the clear taken when a refresh starts.
            if (ref_tick)
            begin
                ref_pend_r <= 1'b1;
            end
            else if (state_r == S_IDLE && init_r)
            begin
                ref_pend_r <= 1'b0;
            end
        end
    end

    // --------------------------------------------------------------------
    // Timer loads on each phase entry
    // --------------------------------------------------------------------
    always_comb
    begin
        tif.load = 1'b0;
        tif.count = fpdc_cnt_t'(1);
        unique case (state_r)
            S_PWR:
            begin
                tif.load = (pwr_cnt_r == fpdc_cnt_t'(POWERUP_WAIT_CYC - 1));
                tif.count = fpdc_cnt_t'(CSR_CYC);
            end
            S_IDLE:
            begin
                tif.load = init_r && ref_pend_r;
                tif.count = fpdc_cnt_t'(CSR_CYC);
            end
            S_ROWSET:
            begin
                tif.load = 1'b1;
                tif.count = fpdc_cnt_t'(RCD_CYC);
            end
            S_COLSET:
            begin
                tif.load = 1'b1;
                tif.count = fpdc_cnt_t'(COL_CYC);
            end
            S_COL:
            begin
                tif.load = col_end;
                tif.count = page_hit ? fpdc_cnt_t'(CP_CYC) : fpdc_cnt_t'(RP_CYC);
            end
            S_CBR_SET:
            begin
                tif.load = tif.done;
                tif.count = fpdc_cnt_t'(RAS_MIN_CYC);
            end
            S_CBR_ROW:
            begin
                tif.load = tif.done;
                tif.count = fpdc_cnt_t'(RP_CYC);
            end
            S_PRE:
            begin
                tif.load = tif.done && (row_cnt_r >= fpdc_cnt_t'(RC_CYC - 1))
                    && (wake_cnt_r != 4'h0);
                tif.count = fpdc_cnt_t'(CSR_CYC);
            end
            default:
            begin
                tif.load = 1'b0;
            end
        endcase
    end

    // --------------------------------------------------------------------
    // Sequencer and pin drivers
    // --------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_r <= S_PWR;
            wake_cnt_r <= 4'h0;
            init_r <= 1'b0;
            cur_row_r <= '0;
            cur_col_r <= '0;
            row_sel_r <= 2'h0;
            lanes_r <= '0;
            wr_r <= 1'b0;
            rsp_valid_r <= 1'b0;
            rsp_rdata_r <= '0;
            row_lo_n_r <= 1'b1;
            row_up_n_r <= 1'b1;
            col_n_r <= '1;
            addr_r <= '0;
            we_n_r <= 1'b1;
            dout_r <= '0;
            doe_r <= 1'b0;
        end
        else
        begin
            rsp_valid_r <= 1'b0;
            unique case (state_r)
                S_PWR:
                begin
                    if (tif.load)
                    begin
                        wake_cnt_r <= 4'(WAKE_CYCLES);
                        col_n_r <= '0;
                        state_r <= S_CBR_SET;
                    end
                end
                S_IDLE:
                begin
                    if (tif.load)
                    begin
                        we_n_r <= 1'b1;
                        col_n_r <= '0;
                        state_r <= S_CBR_SET;
                    end
                    else if (req_valid && req_ready)
                    begin
                        cur_row_r <= req_addr[ADDR_W-1:HALF_W];
                        cur_col_r <= req_addr[HALF_W-1:0];
                        row_sel_r <= req_sel;
                        lanes_r <= req_write ? req_lanes : '1;
                        wr_r <= req_write;
                        addr_r <= req_addr[ADDR_W-1:HALF_W];
                        we_n_r <= !req_write;
                        dout_r <= req_wdata;
                        state_r <= S_ROWSET;
                    end
                end
                S_ROWSET:
                begin
                    row_lo_n_r <= !row_sel_r[0];
                    row_up_n_r <= !row_sel_r[1];
                    state_r <= S_ROW;
                end
                S_ROW:
                begin
                    if (tif.done)
                    begin
                        addr_r <= cur_col_r;
                        state_r <= S_COLSET;
                    end
                end
                S_COLSET:
                begin
                    col_n_r <= ~lanes_r;
                    doe_r <= wr_r;
                    state_r <= S_COL;
                end
                S_COL:
                begin
                    if (col_end)
                    begin
                        rsp_valid_r <= 1'b1;
                        rsp_rdata_r <= wr_r ? '0 : dq_sync_r;
                        col_n_r <= '1;
                        doe_r <= 1'b0;
                        if (page_hit)
                        begin
                            cur_col_r <= req_addr[HALF_W-1:0];
                            lanes_r <= req_write ? req_lanes : '1;
                            wr_r <= req_write;
                            addr_r <= req_addr[HALF_W-1:0];
                            dout_r <= req_wdata;
                            state_r <= S_CPRE;
                        end
                        else
                        begin
                            row_lo_n_r <= 1'b1;
                            row_up_n_r <= 1'b1;
                            state_r <= S_PRE;
                        end
                    end
                end
                S_CPRE:
                begin
                    // Write strobe may only change once the column strobe is high.
                    we_n_r <= !wr_r;
                    if (tif.done)
                    begin
                        state_r <= S_COLSET;
                    end
                end
                S_CBR_SET:
                begin
                    if (tif.done)
                    begin
                        row_lo_n_r <= 1'b0;
                        row_up_n_r <= 1'b0;
                        state_r <= S_CBR_ROW;
                    end
                end
                S_CBR_ROW:
                begin
                    if (tif.done)
                    begin
                        row_lo_n_r <= 1'b1;
                        row_up_n_r <= 1'b1;
                        col_n_r <= '1;
                        if (wake_cnt_r != 4'h0)
                        begin
                            wake_cnt_r <= wake_cnt_r - 4'h1;
                        end
                        state_r <= S_PRE;
                    end
                end
                S_PRE:
                begin
                    we_n_r <= 1'b1;
                    if (tif.done && (row_cnt_r >= fpdc_cnt_t'(RC_CYC - 1)))
                    begin
                        if (wake_cnt_r != 4'h0)
                        begin
                            col_n_r <= '0;
                            state_r <= S_CBR_SET;
                        end
                        else
                        begin
                            init_r <= 1'b1;
                            state_r <= S_IDLE;
                        end
                    end
                end
                default:
                begin
                    state_r <= S_IDLE;
                end
            endcase
        end
    end

    assign rsp_valid = rsp_valid_r;
    assign rsp_rdata = rsp_rdata_r;
    assign init_done = init_r;
    assign row_strobe_lower_n = row_lo_n_r;
    assign row_strobe_upper_n = row_up_n_r;
    assign lane_column_strobes_n = col_n_r;
    assign mux_address_lines = addr_r;
    assign write_n = we_n_r;
    assign data_lines_out = dout_r;
    assign data_lines_oe = doe_r;
endmodule

// *** design/fpdc_timer.sv ***
`timescale 1ns/10ps
module fpdc_timer
    import fpdc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_b,
    fpdc_tmr_if.tmr t
);
    fpdc_cnt_t cnt_r;

    // --------------------------------------------------------------------
    // Down counter: done rises count cycles after a load.
    // --------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cnt_r <= '0;
        end
        else if (t.load)
        begin
            cnt_r <= t.count - fpdc_cnt_t'(1);
        end
        else if (cnt_r != '0)
        begin
            cnt_r <= cnt_r - fpdc_cnt_t'(1);
        end
    end

    // Done does not look at load, so a phase may reload from its own done.
    assign t.done = (cnt_r == '0);
endmodule

// *** dv/fpdc_checker.sv ***
`timescale 1ns/10ps
module fpdc_checker
    import fpdc_pkg::*;
#(
    parameter int POWERUP_WAIT_CYC = 20,
    parameter int ROW_MAX_CYC = 200
)
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic wide_mode,
    input wire logic req_valid,
    input wire logic req_ready,
    input wire logic req_write,
    input wire logic req_half,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic [LANES-1:0] req_lanes,
    input wire logic [DATA_W-1:0] req_wdata,
    input wire logic rsp_valid,
    input wire logic [DATA_W-1:0] rsp_rdata,
    input wire logic init_done,
    input wire logic row_strobe_lower_n,
    input wire logic row_strobe_upper_n,
    input wire logic [LANES-1:0] lane_column_strobes_n,
    input wire logic [HALF_W-1:0] mux_address_lines,
    input wire logic write_n,
    input wire logic [DATA_W-1:0] data_lines_in,
    input wire logic [DATA_W-1:0] data_lines_out,
    input wire logic data_lines_oe
);
    // ----------------------------------------------------------------
    // Strobe spacing counters
    // ----------------------------------------------------------------
    localparam int REF_LIMIT = REF_ROW_CYC + 250;
    logic row_lo;
    logic col_lo;
    logic row_lo_r;
    logic col_lo_r;
    logic row_fall;
    logic col_fall;
    int row_cnt_r;
    int row_gap_r;
    int col_gap_r;
    int ref_gap_r;
    assign row_lo = !row_strobe_lower_n || !row_strobe_upper_n;
    assign col_lo = lane_column_strobes_n != 4'hF;
    assign row_fall = row_lo && !row_lo_r;
    assign col_fall = col_lo && !col_lo_r;
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            row_lo_r <= 1'b0;
            col_lo_r <= 1'b0;
            row_cnt_r <= 0;
            row_gap_r <= 100;
            col_gap_r <= 100;
            ref_gap_r <= 0;
        end
        else
        begin
            row_lo_r <= row_lo;
            col_lo_r <= col_lo;
            row_cnt_r <= row_lo ? row_cnt_r + 1 : 0;
            row_gap_r <= row_fall ? 1 : row_gap_r + 1;
            col_gap_r <= col_fall ? 1 : col_gap_r + 1;
            ref_gap_r <= (row_fall && col_lo) ? 0 : ref_gap_r + 1;
        end
    end
    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    sequence s_cbr_set;
        lane_column_strobes_n == 4'h0 && !row_lo;
    endsequence
    sequence s_cbr_row;
        (!row_strobe_lower_n && !row_strobe_upper_n) [*6];
    endsequence
    chk_cbr_order: assert property (s_cbr_set |=> s_cbr_row)
        else $error("refresh row strobes did not follow column strobes");
    chk_cbr_setup: assert property ((row_fall && col_lo) |-> $past(col_lo))
        else $error("column strobes not set up before refresh row strobe");
    chk_ras_min: assert property ($rose(row_lo) |-> row_lo [*6])
        else $error("row strobe low time too short");
    chk_ras_max: assert property (row_cnt_r < ROW_MAX_CYC)
        else $error("row strobe low time too long");
    chk_rc_gap: assert property (row_fall |-> row_gap_r >= RC_CYC)
        else $error("random cycles too close");
    chk_page_gap: assert property (col_fall |-> col_gap_r >= PC_CYC)
        else $error("column accesses too close");
    chk_ref_gap: assert property (ref_gap_r < REF_LIMIT)
        else $error("refresh interval exceeded");
    chk_precharge: assert property ($fell(row_lo) |-> (!row_lo) [*4])
        else $error("row precharge too short");
    chk_write_hold: assert property ((col_lo && $past(col_lo)) |-> $stable(write_n))
        else $error("write strobe moved while column strobes low");
    chk_early_write: assert property ((col_fall && !write_n) |-> $past(write_n) == 1'b0)
        else $error("write strobe fell after column strobes");
    chk_col_addr: assert property ((col_fall && $past(row_lo)) |-> $stable(mux_address_lines))
        else $error("column address not settled at column strobe");
    chk_oe_write: assert property (data_lines_oe |-> !write_n)
        else $error("data lines driven outside a write");
    chk_rsp_pulse: assert property (rsp_valid |=> !rsp_valid)
        else $error("response longer than one cycle");
    chk_init_gate: assert property (!init_done |-> !req_ready)
        else $error("request accepted before wake-up");
endmodule
bind fpdc_ctrl fpdc_checker #(.POWERUP_WAIT_CYC(POWERUP_WAIT_CYC), .ROW_MAX_CYC(ROW_MAX_CYC))
    i_fpdc_checker (.*);

// *** dv/fpdc_dram_model.sv ***
`timescale 1ns/10ps
module fpdc_dram_model
    import fpdc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic row_strobe_lower_n,
    input wire logic row_strobe_upper_n,
    input wire logic [LANES-1:0] lane_column_strobes_n,
    input wire logic [HALF_W-1:0] mux_address_lines,
    input wire logic write_n,
    input wire logic [DATA_W-1:0] data_lines_in,
    output logic [DATA_W-1:0] q,
    output logic q_en,
    output int refreshes
);
    // ----------------------------------------------------------------
    // Pin sampling memory, one edge behind the registered strobes
    // ----------------------------------------------------------------
    logic [DATA_W-1:0] mem [int];
    logic [1:0] sel;
    logic [HALF_W-1:0] row;
    logic row_p;
    logic col_p;
    logic column_first_refresh;
    int key;
    wire row_on = !row_strobe_lower_n || !row_strobe_upper_n;
    wire col_on = lane_column_strobes_n != 4'hF;
    initial
    begin
        q = '0;
        q_en = 1'b0;
        refreshes = 0;
        row_p = 1'b0;
        col_p = 1'b0;
        column_first_refresh = 1'b0;
    end
    always @(posedge clk_sys)
    begin
        if (row_on && !row_p)
        begin
            column_first_refresh = col_p;
            if (column_first_refresh)
                refreshes <= refreshes + 1;
            else
                row = mux_address_lines;
            sel = {!row_strobe_upper_n, !row_strobe_lower_n};
        end
        if (col_on && !col_p && row_p && !column_first_refresh)
        begin
            key = {sel, row, mux_address_lines};
            if (!write_n)
            begin
                if (!mem.exists(key))
                    mem[key] = '0;
                for (int i = 0; i < LANES; i++)
                    if (!lane_column_strobes_n[i])
                        mem[key][i*9 +: 9] = data_lines_in[i*9 +: 9];
                q_en <= 1'b0;
            end
            else
            begin
                q <= mem.exists(key) ? mem[key] : '0;
                q_en <= 1'b1;
            end
        end
        if (!col_on)
            q_en <= 1'b0;
        if (!row_on)
            column_first_refresh = 1'b0;
        row_p = row_on;
        col_p = col_on;
    end
endmodule

// *** dv/tb_top.sv ***
`timescale 1ns/10ps
module tb_top;
    import fpdc_pkg::*;
    logic clk_sys, rst_b, wide_mode, req_valid, req_ready, req_write, req_half;
    logic [ADDR_W-1:0] req_addr;
    logic [ADDR_W-1:0] a;
    logic [LANES-1:0] req_lanes;
    logic [LANES-1:0] lane_column_strobes_n;
    logic [DATA_W-1:0] req_wdata, rsp_rdata, data_lines_in, data_lines_out, q, last_dl_r;
    logic rsp_valid, init_done, row_strobe_lower_n, row_strobe_upper_n, write_n;
    logic data_lines_oe, q_en;
    logic [HALF_W-1:0] mux_address_lines, row;
    logic [DATA_W:0] exp_q [$];
    logic [DATA_W:0] e;
    logic [DATA_W-1:0] ref_mem [int];
    int seed, miscompares, compares, n, refreshes;
    fpdc_ctrl #(.POWERUP_WAIT_CYC(20), .ROW_MAX_CYC(200)) i_fpdc_ctrl (.*);
    fpdc_dram_model i_fpdc_dram_model (.*);
    // Undriven data lines show a changing value so a late sample cannot pass by luck.
    assign data_lines_in = data_lines_oe ? data_lines_out : (q_en ? q : ~last_dl_r);
    always #5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) last_dl_r <= data_lines_in;
    task check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        compares++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task results;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task issue(input logic w, input logic h, input logic [ADDR_W-1:0] ad,
               input logic [LANES-1:0] l, input logic [DATA_W-1:0] d);
        int k;
        k = {(wide_mode ? 2'b11 : (h ? 2'b10 : 2'b01)), ad};
        req_valid <= 1'b1;
        req_write <= w;
        req_half <= h;
        req_addr <= ad;
        req_lanes <= l;
        req_wdata <= d;
        n = 0;
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (req_ready !== 1'b1 && n < 300);
        if (n >= 300)
            miscompares++;
        if (w)
        begin
            if (!ref_mem.exists(k))
                ref_mem[k] = '0;
            for (int i = 0; i < LANES; i++)
                if (l[i])
                    ref_mem[k][i*9 +: 9] = d[i*9 +: 9];
            exp_q.push_back({1'b0, 36'h0});
        end
        else
            exp_q.push_back({1'b1, ref_mem.exists(k) ? ref_mem[k] : 36'h0});
    endtask
    task drain(input string name);
        req_valid <= 1'b0;
        n = 0;
        while (exp_q.size() != 0 && n < 3000)
        begin
            @(posedge clk_sys);
            n++;
        end
        if (n >= 3000)
            miscompares++;
        @(posedge clk_sys);
        $display("test %s done", name);
    endtask
    always @(posedge clk_sys)
    begin
        if (rst_b === 1'b1 && rsp_valid === 1'b1)
        begin
            if (exp_q.size() == 0)
                check(rsp_rdata, ~rsp_rdata);
            else
            begin
                e = exp_q.pop_front();
                check(rsp_rdata, e[DATA_W-1:0]);
            end
        end
    end
    initial
    begin
        clk_sys = 1'b0;
        rst_b = 1'b0;
        {wide_mode, req_valid, req_write, req_half} = 4'h8;
        req_addr = '0;
        req_lanes = 4'hF;
        req_wdata = '0;
        last_dl_r = '0;
        seed = 41;
        miscompares = 0;
        compares = 0;
        repeat (8) @(posedge clk_sys);
        rst_b <= 1'b1;
        n = 0;
        while (init_done !== 1'b1 && n < 3000)
        begin
            @(posedge clk_sys);
            n++;
        end
        check(36'(init_done), 36'h1);
        check(36'(refreshes), 36'h8);
        $display("test wake-up done");
        row = 9'($random(seed));
        for (int i = 0; i < 16; i++)
            issue(i < 8, 1'b0, {row, 9'((i % 8) * 37)}, 4'hF, 36'({$random(seed), $random(seed)}));
        drain("page");
        a = 18'($random(seed));
        for (int i = 0; i < 5; i++)
            issue(i < 4, 1'b0, a, (i < 4) ? 4'(1 << i) : 4'hF, 36'({$random(seed), $random(seed)}));
        drain("lanes");
        wide_mode <= 1'b0;
        @(posedge clk_sys);
        for (int i = 0; i < 4; i++)
            issue(i < 2, 1'(i), a, 4'hF, 36'({$random(seed), $random(seed)}));
        drain("half width");
        for (int p = 0; p < 2; p++)
        begin
            wide_mode <= 1'(p);
            @(posedge clk_sys);
            for (int i = 0; i < 30; i++)
                issue(1'($random(seed)), 1'($random(seed)), 18'($random(seed)) & 18'h00C03,
                      4'($random(seed)) | 4'h1, 36'({$random(seed), $random(seed)}));
            drain("random");
        end
        repeat (1800) @(posedge clk_sys);
        check(36'(refreshes > 8), 36'h1);
        issue(1'b0, 1'b0, {row, 9'h0}, 4'hF, 36'h0);
        drain("refresh");
        results;
    end
    initial
    begin
        repeat (40000) @(posedge clk_sys);
        miscompares++;
        results;
    end
endmodule

// *** pkg/fpdc_pkg.sv ***
package fpdc_pkg;

    // --------------------------------------------------------------------
    // Geometry
    // --------------------------------------------------------------------
    localparam int ADDR_W = 18;
    localparam int HALF_W = 9;
    localparam int DATA_W = 36;
    localparam int LANES = 4;
    localparam int ROWS = 512;
    localparam int WAKE_CYCLES = 8;
    localparam int SYNC_STAGES = 2;
    localparam int CNT_W = 14;

    // --------------------------------------------------------------------
    // Times in their own units and derived clock counts
    // --------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int POWERUP_US = 100;
    localparam int ROW_ACTIVE_MIN_NS = 60;
    localparam int ROW_ACTIVE_MAX_NS = 100000;
    localparam int ROW_PRECHARGE_NS = 40;
    localparam int RANDOM_CYCLE_NS = 110;
    localparam int PAGE_CYCLE_NS = 40;
    localparam int PAGE_COLUMN_PRECHARGE_NS = 10;
    localparam int ROW_TO_COLUMN_MIN_NS = 20;
    localparam int ROW_ACCESS_NS = 60;
    localparam int COLUMN_ACCESS_NS = 20;
    localparam int REFRESH_COLUMN_SETUP_NS = 10;
    localparam int REFRESH_INTERVAL_MS = 8;

    // Least times round up, longest times round down.
    localparam int POWERUP_CYC = (POWERUP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RAS_MIN_CYC = (ROW_ACTIVE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RAS_MAX_CYC = ROW_ACTIVE_MAX_NS / CLK_PERIOD_NS;
    localparam int RP_CYC = (ROW_PRECHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RC_CYC = (RANDOM_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PC_CYC = (PAGE_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CP_CYC = (PAGE_COLUMN_PRECHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RCD_CYC = (ROW_TO_COLUMN_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RAC_CYC = (ROW_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CAC_CYC = (COLUMN_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CSR_CYC = (REFRESH_COLUMN_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int REF_ROW_CYC = (REFRESH_INTERVAL_MS * 1000000 / ROWS) / CLK_PERIOD_NS;

    // Column low time covers access plus the data pin synchroniser.
    localparam int COL_CYC = CAC_CYC + SYNC_STAGES;
    localparam int PAGE_MARGIN_CYC = 64;

    typedef logic [CNT_W-1:0] fpdc_cnt_t;

    typedef enum logic [3:0] {
        S_PWR,
        S_IDLE,
        S_ROWSET,
        S_ROW,
        S_COLSET,
        S_COL,
        S_CPRE,
        S_PRE,
        S_CBR_SET,
        S_CBR_ROW
    } fpdc_state_e;

endpackage

// *** pkg/fpdc_tmr_if.sv ***
`timescale 1ns/10ps
interface fpdc_tmr_if;
    import fpdc_pkg::*;
    logic load;
    fpdc_cnt_t count;
    logic done;
    modport ctl (output load, output count, input done);
    modport tmr (input load, input count, output done);
endinterface
